// ==== hw/ccrd_pkg.sv ====
// Constants and types for the clock ratio configuration decoder
package ccrd_pkg;

  // ==========================================================
  // Widths
  localparam int SYS_PLL_MULT_FIELD_W = 4;
  localparam int CPLL_W = 7;
  localparam int LBCM_W = 1;
  localparam int DDCM_W = 1;
  localparam int RATIO_W = 6;
  localparam int CRAT_W = 3;
  localparam int VDIV_W = 4;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // Wishbone register byte offsets
  localparam logic [7:0] REG_CAPT = 8'h00;
  localparam logic [7:0] REG_CSB = 8'h04;
  localparam logic [7:0] REG_CORE = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;

  // ==========================================================
  // System multiplier codes
  localparam logic [SYS_PLL_MULT_FIELD_W-1:0] SYS_PLL_MULT_FIELD_X16 = 4'h0;
  localparam logic [SYS_PLL_MULT_FIELD_W-1:0] SYS_PLL_MULT_FIELD_MIN = 4'h2;
  localparam logic [SYS_PLL_MULT_FIELD_W-1:0] SYS_PLL_MULT_FIELD_DIV_MAX = 4'h8;
  localparam logic [RATIO_W-1:0] RATIO_X16 = 6'h10;
  localparam logic [RATIO_W-1:0] RATIO_BAD = 6'h00;

  // ==========================================================
  // Core PLL field positions and codes
  localparam int CPLL_VDIV_LO = 0;
  localparam int CPLL_RAT_LO = 2;
  localparam int CPLL_HALF = 6;
  localparam logic [3:0] CRAT_OFF = 4'h0;
  localparam logic [3:0] CRAT_1 = 4'h1;
  localparam logic [3:0] CRAT_2 = 4'h2;
  localparam logic [3:0] CRAT_3 = 4'h3;
  localparam logic [VDIV_W-1:0] VDIV_2 = 4'h2;
  localparam logic [VDIV_W-1:0] VDIV_4 = 4'h4;
  localparam logic [VDIV_W-1:0] VDIV_8 = 4'h8;

  // Core ratio in half steps: 2 = 1:1, 3 = 1.5:1 ... 6 = 3:1
  localparam logic [CRAT_W-1:0] HALF_0 = 3'h0;

  // ==========================================================
  // Capture sequencer states
  typedef enum logic [1:0] {
    CCRD_SAMPLE = 2'b00,
    CCRD_LATCH = 2'b01,
    CCRD_RUN = 2'b11
  } ccrd_state_t;

endpackage

// ==== hw/ccrd_sync.sv ====
// Three stage synchroniser with agreement filter
`timescale 1ns/1ps
module ccrd_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import ccrd_pkg::*;

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ==========================================================
  // Stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ==========================================================
  // Accept change once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '0;
    end else if (s2_r == s3_r) begin
      q_o <= s3_r;
    end
  end
endmodule

// ==== hw/ccrd_top.sv ====
// Reset configuration capture and clock ratio decode
`timescale 1ns/1ps

module ccrd_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_in_i,
  input wire logic hard_reset_in_i,
  input wire logic host_mode_i,
  input wire logic [ccrd_pkg::SYS_PLL_MULT_FIELD_W-1:0] sys_pll_mult_field_i,
  input wire logic input_div_strap_i,
  input wire logic [ccrd_pkg::CPLL_W-1:0] core_pll_cfg_field_i,
  input wire logic [ccrd_pkg::LBCM_W-1:0] local_bus_clock_mode_i,
  input wire logic [ccrd_pkg::DDCM_W-1:0] dram_clock_mode_i,
  output logic cfg_pin_oe_n_o,
  output logic primary_clk_sel_host_o,
  output logic sync_out_div2_o,
  output logic [ccrd_pkg::RATIO_W-1:0] csb_ratio_o,
  output logic csb_ratio_valid_o,
  output logic core_pll_bypass_o,
  output logic [ccrd_pkg::CRAT_W-1:0] core_ratio_half_o,
  output logic [ccrd_pkg::VDIV_W-1:0] core_vco_div_o,
  output logic cfg_captured_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o
);
  import ccrd_pkg::*;

  localparam int PIN_W = SYS_PLL_MULT_FIELD_W + 1 + CPLL_W + LBCM_W + DDCM_W + 1;

  // ==========================================================
  // Decode functions
  function automatic logic [RATIO_W-1:0] csb_ratio_f(input logic [SYS_PLL_MULT_FIELD_W-1:0] sys_pll_mult_field,
                                                     input logic div_strap);
    logic [RATIO_W-1:0] r;
    r = RATIO_BAD;
    if (sys_pll_mult_field == SYS_PLL_MULT_FIELD_X16) begin
      r = div_strap ? RATIO_BAD : RATIO_X16;
    end else if (sys_pll_mult_field >= SYS_PLL_MULT_FIELD_MIN) begin
      r = {{(RATIO_W-SYS_PLL_MULT_FIELD_W){1'b0}}, sys_pll_mult_field};
      if (div_strap && sys_pll_mult_field > SYS_PLL_MULT_FIELD_DIV_MAX) begin
        r = RATIO_BAD;
      end
    end
    return r;
  endfunction

  function automatic logic [CRAT_W-1:0] core_ratio_f(input logic [3:0] code,
                                                     input logic half);
    logic [CRAT_W-1:0] r;
    r = HALF_0;
    unique case (code)
      CRAT_1: r = half ? 3'h3 : 3'h2;
      CRAT_2: r = half ? 3'h5 : 3'h4;
      CRAT_3: r = 3'h6;
      default: r = HALF_0;
    endcase
    return r;
  endfunction

  function automatic logic [VDIV_W-1:0] vco_div_f(input logic [1:0] code);
    logic [VDIV_W-1:0] d;
    d = VDIV_8;
    if (code == 2'b00) begin
      d = VDIV_2;
    end else if (code == 2'b01) begin
      d = VDIV_4;
    end
    return d;
  endfunction

  // ==========================================================
  // Synchronise pins and reset inputs
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic [1:0] rst_raw;
  logic [1:0] rst_s;
  logic por_s;
  logic hrst_s;

  assign pins_raw = {host_mode_i, dram_clock_mode_i, local_bus_clock_mode_i,
                     core_pll_cfg_field_i, input_div_strap_i, sys_pll_mult_field_i};
  assign rst_raw = {hard_reset_in_i, power_on_reset_in_i};
  assign por_s = rst_s[0];
  assign hrst_s = rst_s[1];

  ccrd_sync #(.W(PIN_W)) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  ccrd_sync #(.W(2)) u_rst_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(rst_raw),
    .q_o(rst_s)
  );

  // ==========================================================
  // Capture sequencer
  ccrd_state_t state_r;
  logic [PIN_W-1:0] cap_r;
  logic por_d_r;
  logic por_fall;

  assign por_fall = por_d_r & ~por_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_d_r <= 1'b0;
    end else begin
      por_d_r <= por_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= CCRD_SAMPLE;
    end else begin
      unique case (state_r)
        CCRD_SAMPLE: if (por_fall) state_r <= CCRD_LATCH;
        CCRD_LATCH: state_r <= CCRD_RUN;
        CCRD_RUN: if (por_s) state_r <= CCRD_SAMPLE;
        default: state_r <= CCRD_SAMPLE;
      endcase
    end
  end

  // Capture only on power-on release; later changes are ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_r <= '0;
    end else if (state_r == CCRD_SAMPLE && por_fall) begin
      cap_r <= pins_s;
    end
  end

  // Receivers active (pins high-z) while hard reset held, before capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_pin_oe_n_o <= 1'b1;
    end else begin
      cfg_pin_oe_n_o <= hrst_s | (state_r != CCRD_RUN);
    end
  end

  // ==========================================================
  // Decoded outputs, loaded once after capture
  logic [SYS_PLL_MULT_FIELD_W-1:0] cap_sys_pll_mult_field;
  logic cap_div;
  logic [CPLL_W-1:0] cap_cpll;
  logic cap_lbcm;
  logic cap_ddcm;
  logic cap_host;

  assign cap_sys_pll_mult_field = cap_r[SYS_PLL_MULT_FIELD_W-1:0];
  assign cap_div = cap_r[SYS_PLL_MULT_FIELD_W];
  assign cap_cpll = cap_r[SYS_PLL_MULT_FIELD_W+1 +: CPLL_W];
  assign cap_lbcm = cap_r[SYS_PLL_MULT_FIELD_W+1+CPLL_W];
  assign cap_ddcm = cap_r[SYS_PLL_MULT_FIELD_W+2+CPLL_W];
  assign cap_host = cap_r[PIN_W-1];

  logic [1:0] bus_modes_r;
  logic [RATIO_W-1:0] csb_ratio_nxt;
  logic load_en;

  assign load_en = (state_r == CCRD_LATCH);
  assign csb_ratio_nxt = csb_ratio_f(cap_sys_pll_mult_field, cap_div & cap_host);

  // Bus clock ratio
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csb_ratio_o <= RATIO_BAD;
    end else if (load_en) begin
      csb_ratio_o <= csb_ratio_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csb_ratio_valid_o <= 1'b0;
    end else if (load_en) begin
      csb_ratio_valid_o <= (csb_ratio_nxt != RATIO_BAD);
    end
  end

  // Primary clock source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_clk_sel_host_o <= 1'b1;
    end else if (load_en) begin
      primary_clk_sel_host_o <= cap_host;
    end
  end

  // Sync output divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_out_div2_o <= 1'b0;
    end else if (load_en) begin
      sync_out_div2_o <= cap_div;
    end
  end

  // Bus clock modes, reported only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_modes_r <= 2'b00;
    end else if (load_en) begin
      bus_modes_r <= {cap_ddcm, cap_lbcm};
    end
  end

  logic [3:0] cpll_code;
  logic cpll_off;
  assign cpll_code = cap_cpll[CPLL_RAT_LO +: 4];
  assign cpll_off = (cpll_code == CRAT_OFF);

  // Core PLL bypass
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_pll_bypass_o <= 1'b1;
    end else if (load_en) begin
      core_pll_bypass_o <= cpll_off;
    end
  end

  // Core to bus ratio in half steps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_ratio_half_o <= HALF_0;
    end else if (load_en && cpll_off) begin
      core_ratio_half_o <= HALF_0;
    end else if (load_en) begin
      core_ratio_half_o <= core_ratio_f(cpll_code, cap_cpll[CPLL_HALF]);
    end
  end

  // Core VCO divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_vco_div_o <= VDIV_2;
    end else if (load_en && cpll_off) begin
      core_vco_div_o <= VDIV_2;
    end else if (load_en) begin
      core_vco_div_o <= vco_div_f(cap_cpll[CPLL_VDIV_LO +: 2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_captured_o <= 1'b0;
    end else begin
      cfg_captured_o <= (state_r == CCRD_RUN);
    end
  end

  // ==========================================================
  // Wishbone slave, one wait state
  logic [31:0] rd_mux;
  logic ctrl_lock_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      REG_CAPT: rd_mux = {{(32-PIN_W){1'b0}}, cap_r};
      REG_CSB: rd_mux = {22'h0, bus_modes_r, sync_out_div2_o, primary_clk_sel_host_o,
                         csb_ratio_o};
      REG_CORE: rd_mux = {24'h0, core_vco_div_o, core_ratio_half_o, core_pll_bypass_o};
      REG_STAT: rd_mux = {27'h0, hrst_s, por_s, cfg_pin_oe_n_o, state_r};
      REG_CTRL: rd_mux = {31'h0, ctrl_lock_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Read data registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_mux;
    end
  end

  // Scratch lock bit; decoded clock state is read only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_lock_r <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i == REG_CTRL) begin
      ctrl_lock_r <= wb_dat_i[0];
    end
  end
endmodule

// ==== tb/ccrd_monitor.sv ====
// Port assertions for the clock ratio decoder
`timescale 1ns/1ps
module ccrd_monitor import ccrd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_in_i,
  input wire logic cfg_pin_oe_n_o,
  input wire logic primary_clk_sel_host_o,
  input wire logic sync_out_div2_o,
  input wire logic [ccrd_pkg::RATIO_W-1:0] csb_ratio_o,
  input wire logic csb_ratio_valid_o,
  input wire logic core_pll_bypass_o,
  input wire logic [ccrd_pkg::CRAT_W-1:0] core_ratio_half_o,
  input wire logic [ccrd_pkg::VDIV_W-1:0] core_vco_div_o,
  input wire logic cfg_captured_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ======
  // Decode relations
  property p_valid; csb_ratio_valid_o == (csb_ratio_o != 6'h00); endproperty
  a_valid: assert property (p_valid) else $error("ratio valid flag wrong");
  property p_byp; core_pll_bypass_o |-> core_ratio_half_o == 3'h0; endproperty
  a_byp: assert property (p_byp) else $error("bypass with core ratio");
  property p_vdiv;
    cfg_captured_o && !core_pll_bypass_o |-> core_vco_div_o inside {4'h2, 4'h4, 4'h8};
  endproperty
  a_vdiv: assert property (p_vdiv) else $error("vco divider illegal");
  property p_half; core_ratio_half_o != 3'h1 && core_ratio_half_o != 3'h7; endproperty
  a_half: assert property (p_half) else $error("core ratio illegal");
  // ======
  // Capture sequence
  sequence s_quiet; !power_on_reset_in_i [*8] ##1 !power_on_reset_in_i [*4]; endsequence
  sequence s_por_up; $rose(power_on_reset_in_i); endsequence
  property p_static;
    s_quiet |-> $stable({csb_ratio_o, core_ratio_half_o, core_vco_div_o, core_pll_bypass_o,
      primary_clk_sel_host_o, sync_out_div2_o});
  endproperty
  a_static: assert property (p_static) else $error("selection moved");
  property p_oe_por; s_por_up |-> ##[1:8] cfg_pin_oe_n_o; endproperty
  a_oe_por: assert property (p_oe_por) else $error("pins not inputs");
  property p_oe_fall;
    $fell(cfg_pin_oe_n_o) |-> cfg_captured_o && !power_on_reset_in_i;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("pins driven early");
  // ======
  // Register bus
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
endmodule
bind ccrd_top ccrd_monitor u_mon (.clk_i, .rst_i, .power_on_reset_in_i, .cfg_pin_oe_n_o,
  .primary_clk_sel_host_o, .sync_out_div2_o, .csb_ratio_o, .csb_ratio_valid_o,
  .core_pll_bypass_o, .core_ratio_half_o, .core_vco_div_o, .cfg_captured_o, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o);

// ==== tb/tb_ccrd_top.sv ====
// Self-checking bench for the clock ratio decoder
`timescale 1ns/1ps
module tb_ccrd_top;
  import ccrd_pkg::*;
  logic clk_i = 0, rst_i = 1, power_on_reset_in_i = 1, hard_reset_in_i = 0, host_mode_i = 0;
  logic input_div_strap_i = 0, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic [3:0] sys_pll_mult_field_i = 4'h0, wb_sel_i = 4'hf;
  logic [6:0] core_pll_cfg_field_i = 7'h00;
  logic [0:0] local_bus_clock_mode_i = 1'b0, dram_clock_mode_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
  logic cfg_pin_oe_n_o, primary_clk_sel_host_o, sync_out_div2_o, csb_ratio_valid_o;
  logic core_pll_bypass_o, cfg_captured_o, wb_ack_o;
  logic [5:0] csb_ratio_o;
  logic [2:0] core_ratio_half_o;
  logic [3:0] core_vco_div_o;
  int failures = 0, tests_run = 0;
  integer seed = 32'hbca47a5a;
  ccrd_top dut_u (.clk_i, .rst_i, .power_on_reset_in_i, .hard_reset_in_i, .host_mode_i,
    .sys_pll_mult_field_i, .input_div_strap_i, .core_pll_cfg_field_i, .local_bus_clock_mode_i,
    .dram_clock_mode_i, .cfg_pin_oe_n_o, .primary_clk_sel_host_o, .sync_out_div2_o,
    .csb_ratio_o, .csb_ratio_valid_o, .core_pll_bypass_o, .core_ratio_half_o, .core_vco_div_o,
    .cfg_captured_o, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o);
  always #2.5 clk_i = ~clk_i;
  // ======
  // Checking and expectations
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function logic [5:0] e_ratio(input logic [3:0] c, input logic h, input logic s);
    if (h && s) return (c >= 4'h2 && c <= 4'h8) ? {2'h0, c} : 6'h00;
    return c == 4'h0 ? 6'h10 : c == 4'h1 ? 6'h00 : {2'h0, c};
  endfunction
  function logic [2:0] e_half(input logic [6:0] k);
    case (k[5:2])
      4'h1: return {2'h1, k[6]};
      4'h2: return {2'h2, k[6]};
      4'h3: return 3'h6;
      default: return 3'h0;
    endcase
  endfunction
  // ======
  // Bus and capture drivers
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    n = 0;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    if (wb_ack_o !== 1'b1) begin failures++; close_out; end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  task cap(input logic [3:0] m, input logic [6:0] k, input logic h, s, l, d);
    int n;
    if (k[5:2] == 4'h3) k[6] = 1'b0;
    @(posedge clk_i);
    power_on_reset_in_i <= 1;
    sys_pll_mult_field_i <= m;
    core_pll_cfg_field_i <= k;
    host_mode_i <= h;
    input_div_strap_i <= s;
    local_bus_clock_mode_i <= l;
    dram_clock_mode_i <= d;
    repeat (8) @(posedge clk_i);
    power_on_reset_in_i <= 0;
    n = 0;
    do begin @(posedge clk_i); n++; end while (cfg_pin_oe_n_o !== 1'b0 && n < 40);
    if (cfg_pin_oe_n_o !== 1'b0) begin failures++; close_out; end
    // Pins move after capture; outputs must not follow
    sys_pll_mult_field_i <= ~m;
    core_pll_cfg_field_i <= ~k;
    host_mode_i <= ~h;
    input_div_strap_i <= ~s;
    local_bus_clock_mode_i <= ~l;
    dram_clock_mode_i <= ~d;
    repeat (6) @(posedge clk_i);
    chk(csb_ratio_o, e_ratio(m, h, s));
    chk(csb_ratio_valid_o, e_ratio(m, h, s) != 6'h00);
    chk(primary_clk_sel_host_o, h);
    chk(sync_out_div2_o, s);
    chk(core_pll_bypass_o, k[5:2] == 4'h0);
    chk(core_ratio_half_o, e_half(k));
    if (k[5:2] != 4'h0) chk(core_vco_div_o, k[1] ? 4'h8 : k[0] ? 4'h4 : 4'h2);
    chk(cfg_captured_o, 1);
    wb(REG_CSB, 0, 0);
    chk(rd[9:0], {d, l, s, h, e_ratio(m, h, s)});
    wb(REG_CAPT, 0, 0);
    chk(rd, {17'h0, h, d, l, k, s, m});
    wb(REG_CORE, 0, 0);
    chk(rd[3:0], {e_half(k), k[5:2] == 4'h0});
    wb(REG_STAT, 0, 0);
    chk(rd[4:0], 5'h03);
    $display("capture test done");
  endtask
  // ======
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    chk({cfg_pin_oe_n_o, primary_clk_sel_host_o, core_pll_bypass_o, cfg_captured_o}, 4'he);
    chk({csb_ratio_o, core_ratio_half_o, core_vco_div_o, wb_ack_o}, 14'h0004);
    rst_i <= 0;
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      if (i < 48) r[5:4] = 2'h0;
      if (i < 64) r[13:8] = i[5:0];
      cap(r[11:8], r[6:0], r[12], r[13], r[14], r[15]);
    end
    hard_reset_in_i <= 1;
    power_on_reset_in_i <= 1;
    repeat (8) @(posedge clk_i);
    power_on_reset_in_i <= 0;
    repeat (20) @(posedge clk_i);
    chk(cfg_pin_oe_n_o, 1);
    hard_reset_in_i <= 0;
    repeat (20) @(posedge clk_i);
    chk(cfg_pin_oe_n_o, 0);
    $display("hard reset test done");
    wb(REG_CTRL, 1, 32'h1);
    wb(REG_CTRL, 0, 0);
    chk(rd, 32'h1);
    wb(8'h14, 1, 32'hffffffff);
    wb(8'h14, 0, 0);
    chk(rd, 32'h0);
    $display("register test done");
    close_out;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    failures++;
    close_out;
  end
endmodule
